// ---- hw/axil_port.sv ----
// axi4-lite slave front end: one write and one read at a time
module axil_port #(
  parameter int ADDR_W = 19
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic wr_stb,
  output logic [ADDR_W-3:0] wr_idx,
  output logic [31:0] wr_data,
  output logic [3:0] wr_strb,
  input wire logic wr_ok,
  output logic rd_stb,
  output logic [ADDR_W-3:0] rd_idx,
  input wire logic [15:0] rd_data,
  input wire logic rd_ok
);

  //////////////////////////////////////////////////////////////////////////////
  // write happens once address and data are both held
  assign wr_stb = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;

  // address and data captured in either order
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
        s_axi_awready <= 1'b0;
      else if (wr_stb)
        s_axi_awready <= 1'b1;
      if (s_axi_wvalid && s_axi_wready)
        s_axi_wready <= 1'b0;
      else if (wr_stb)
        s_axi_wready <= 1'b1;
    end
  end

  // payload holding, no reset needed
  always_ff @(posedge aclk)
  begin
    if (s_axi_awvalid && s_axi_awready)
      wr_idx <= s_axi_awaddr[ADDR_W-1:2];
    if (s_axi_wvalid && s_axi_wready)
    begin
      wr_data <= s_axi_wdata;
      wr_strb <= s_axi_wstrb;
    end
    if (s_axi_arvalid && s_axi_arready)
      rd_idx <= s_axi_araddr[ADDR_W-1:2];
  end

  // write response
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= serial_pkg::RESP_OKAY;
    end
    else if (wr_stb)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_ok ? serial_pkg::RESP_OKAY : serial_pkg::RESP_SLVERR;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  //////////////////////////////////////////////////////////////////////////////
  // read: address taken, one cycle of lookup, then data
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b1;
      rd_stb <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= serial_pkg::RESP_OKAY;
    end
    else
    begin
      rd_stb <= s_axi_arvalid && s_axi_arready;
      if (s_axi_arvalid && s_axi_arready)
        s_axi_arready <= 1'b0;
      else if (s_axi_rvalid && s_axi_rready)
        s_axi_arready <= 1'b1;
      if (rd_stb)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= {16'h0000, rd_data};
        s_axi_rresp <= rd_ok ? serial_pkg::RESP_OKAY : serial_pkg::RESP_SLVERR;
      end
      else if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // checks
  a_read_answer: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_arvalid && s_axi_arready |-> ##2 s_axi_rvalid)
    else $error("read answer not two cycles after address");

  a_write_answer: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_stb |=> s_axi_bvalid)
    else $error("write answer missing");

endmodule : axil_port

// ---- hw/event_flag_cell.sv ----
// one sticky event flag with hot and soft reset
module event_flag_cell #(
  parameter logic RESET_VAL = 1'b0
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic soft_clear,
  input wire logic set_event,
  input wire logic clear_event,
  output logic flag
);

  //////////////////////////////////////////////////////////////////////////////
  // set wins over a clear in the same cycle
  always_ff @(posedge aclk)
  begin
    if (!aresetn || soft_clear)
      flag <= RESET_VAL;
    else
      flag <= set_event | (flag & ~clear_event);
  end

  //////////////////////////////////////////////////////////////////////////////
  // checks
  a_soft_restore: assert property (@(posedge aclk) disable iff (!aresetn)
    soft_clear |=> flag == RESET_VAL)
    else $error("flag not restored by soft reset");

  a_set_wins: assert property (@(posedge aclk) disable iff (!aresetn)
    set_event && !soft_clear |=> flag)
    else $error("event lost against clear");

endmodule : event_flag_cell

// ---- hw/sync_serial_ch1_register_bank.sv ----
// The AXI4-Lite register port was decided locally.
`include "serial_cfg.svh"
// Summary of operation
// - overrun flag cleared only by writing one or by a hot or soft reset
// - rx full flag read-only, cleared reading rx data
// - tx empty read-only, resets set, cleared writing tx
// - four-bit char length field, reset seven
// - six mode setting bits, reset zero
// - soft reset and module enable bits
// - sixteen-bit tx and rx data, reset zero
// - flags follow hot and soft reset
module sync_serial_ch1_register_bank #(
  parameter int ADDR_W = 19
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic transfer_active_in,
  input wire logic overrun_event,
  input wire logic transfer_end_event,
  input wire logic rx_load,
  input wire logic [15:0] rx_word,
  input wire logic tx_taken,
  output logic [3:0] char_length,
  output logic pullup_enable,
  output logic divider_bypass,
  output logic low_bit_first,
  output logic clock_phase,
  output logic clock_polarity,
  output logic master_select,
  output logic module_enable,
  output logic soft_reset,
  output logic [15:0] tx_word,
  output logic tx_load,
  output logic irq
);

  localparam int IDX_W = ADDR_W - 2;

  //////////////////////////////////////////////////////////////////////////////
  // elaboration check: the highest index must fit the address
  if (ADDR_W < 17)
  begin : g_addr_check
    $error("ADDR_W too small for the register map");
  end

  // register indices at the bus index width
  localparam logic [IDX_W-1:0] I_MODE = IDX_W'(`IDX_MODE);
  localparam logic [IDX_W-1:0] I_CTRL = IDX_W'(`IDX_CTRL);
  localparam logic [IDX_W-1:0] I_TXD = IDX_W'(`IDX_TXD);
  localparam logic [IDX_W-1:0] I_RXD = IDX_W'(`IDX_RXD);
  localparam logic [IDX_W-1:0] I_FLAGS = IDX_W'(`IDX_FLAGS);
  localparam logic [IDX_W-1:0] I_ENABLES = IDX_W'(`IDX_ENABLES);
  localparam logic [3:0] FLAG_INIT = `FLAG_RESET;

  //////////////////////////////////////////////////////////////////////////////
  // byte-lane merge, reserved bits forced to zero
  function automatic serial_pkg::word16_type merge16(
    input serial_pkg::word16_type old,
    input logic [31:0] data,
    input logic [3:0] strb,
    input serial_pkg::word16_type mask
  );
    serial_pkg::word16_type v;
    v = old;
    if (strb[0])
      v[7:0] = data[7:0];
    if (strb[1])
      v[15:8] = data[15:8];
    return v & mask;
  endfunction : merge16

  //////////////////////////////////////////////////////////////////////////////
  // bus front end
  logic wr_stb; // one-cycle write pulse
  logic [IDX_W-1:0] wr_idx; // write register index
  logic [31:0] wr_data; // write data
  logic [3:0] wr_strb; // write byte enables
  logic wr_ok; // write index is mapped
  logic rd_stb; // one-cycle read pulse
  logic [IDX_W-1:0] rd_idx; // read register index
  serial_pkg::word16_type rd_word; // selected read value
  logic rd_ok; // read index is mapped

  axil_port #(
    .ADDR_W(ADDR_W)
  ) u_port (
    .aclk(aclk),
    .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .wr_stb(wr_stb),
    .wr_idx(wr_idx),
    .wr_data(wr_data),
    .wr_strb(wr_strb),
    .wr_ok(wr_ok),
    .rd_stb(rd_stb),
    .rd_idx(rd_idx),
    .rd_data(rd_word),
    .rd_ok(rd_ok)
  );

  //////////////////////////////////////////////////////////////////////////////
  // address decode
  wire w_mode = wr_stb && (wr_idx == I_MODE);
  wire w_ctrl = wr_stb && (wr_idx == I_CTRL);
  wire w_txd = wr_stb && (wr_idx == I_TXD);
  wire w_flags = wr_stb && (wr_idx == I_FLAGS);
  wire w_enables = wr_stb && (wr_idx == I_ENABLES);
  wire r_mode = rd_idx == I_MODE;
  wire r_ctrl = rd_idx == I_CTRL;
  wire r_txd = rd_idx == I_TXD;
  wire r_rxd = rd_idx == I_RXD;
  wire r_flags = rd_idx == I_FLAGS;
  wire r_enables = rd_idx == I_ENABLES;
  // receive data is read only: a write to it is accepted and ignored
  assign wr_ok = (wr_idx == I_MODE) || (wr_idx == I_CTRL) || (wr_idx == I_TXD)
    || (wr_idx == I_RXD) || (wr_idx == I_FLAGS) || (wr_idx == I_ENABLES);
  assign rd_ok = r_mode || r_ctrl || r_txd || r_rxd || r_flags || r_enables;

  //////////////////////////////////////////////////////////////////////////////
  // register state, hot reset only
  serial_pkg::word16_type mode_reg; // mode settings
  serial_pkg::word16_type ctrl_reg; // control bits
  serial_pkg::word16_type txd_reg; // transmit word
  serial_pkg::word16_type rxd_reg; // receive word
  serial_pkg::word16_type enables_reg; // interrupt enables
  logic busy_reg; // transfer in progress
  logic tx_load_reg; // pulse to engine on transmit write
  logic irq_reg; // interrupt request

  // mode register
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      mode_reg <= `MODE_RESET;
    else if (w_mode)
      mode_reg <= merge16(mode_reg, wr_data, wr_strb, `MODE_MASK);
  end

  // control register
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      ctrl_reg <= `CTRL_RESET;
    else if (w_ctrl)
      ctrl_reg <= merge16(ctrl_reg, wr_data, wr_strb, `CTRL_MASK);
  end

  // transmit data and load pulse
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      txd_reg <= `DATA_RESET;
      tx_load_reg <= 1'b0;
    end
    else
    begin
      tx_load_reg <= w_txd;
      if (w_txd)
        txd_reg <= merge16(txd_reg, wr_data, wr_strb, 16'hffff);
    end
  end

  // receive data from the engine
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      rxd_reg <= `DATA_RESET;
    else if (rx_load)
      rxd_reg <= rx_word;
  end

  // interrupt enables
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      enables_reg <= `ENABLE_RESET;
    else if (w_enables)
      enables_reg <= merge16(enables_reg, wr_data, wr_strb, `ENABLE_MASK);
  end

  // busy status follows the engine
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      busy_reg <= 1'b0;
    else
      busy_reg <= transfer_active_in;
  end

  //////////////////////////////////////////////////////////////////////////////
  // event flags: set by engine, cleared by software action
  logic [3:0] flags; // event flag vector
  logic [3:0] flag_set; // set events
  logic [3:0] flag_clr; // software clears
  wire w1c_lane = w_flags && wr_strb[0];
  assign flag_set[`FLAG_OVR] = overrun_event;
  assign flag_set[`FLAG_TEND] = transfer_end_event;
  assign flag_set[`FLAG_RXF] = rx_load;
  assign flag_set[`FLAG_TXE] = tx_taken;
  assign flag_clr[`FLAG_OVR] = w1c_lane && wr_data[`FLAG_OVR];
  assign flag_clr[`FLAG_TEND] = w1c_lane && wr_data[`FLAG_TEND];
  assign flag_clr[`FLAG_RXF] = rd_stb && r_rxd;
  assign flag_clr[`FLAG_TXE] = w_txd;

  // one cell per flag, soft reset restores initial values
  for (genvar i = 0; i < 4; i++)
  begin : g_flag
    event_flag_cell #(
      .RESET_VAL(FLAG_INIT[i])
    ) u_flag (
      .aclk(aclk),
      .aresetn(aresetn),
      .soft_clear(ctrl_reg[`CTRL_SOFT]),
      .set_event(flag_set[i]),
      .clear_event(flag_clr[i]),
      .flag(flags[i])
    );
  end

  // interrupt while any flag meets its enable
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      irq_reg <= 1'b0;
    else
      irq_reg <= |(flags & enables_reg[3:0]);
  end

  //////////////////////////////////////////////////////////////////////////////
  // read selection, unmapped reads zero
  assign rd_word = r_mode ? mode_reg
    : r_ctrl ? ctrl_reg
    : r_txd ? txd_reg
    : r_rxd ? rxd_reg
    : r_flags ? {8'h00, busy_reg, 3'b000, flags}
    : r_enables ? enables_reg
    : 16'h0000;

  //////////////////////////////////////////////////////////////////////////////
  // outputs straight from registers
  assign char_length = mode_reg[`MODE_LEN_HI:`MODE_LEN_LO];
  assign pullup_enable = mode_reg[`MODE_PULLUP];
  assign divider_bypass = mode_reg[`MODE_BYPASS];
  assign low_bit_first = mode_reg[`MODE_LSB];
  assign clock_phase = mode_reg[`MODE_PHASE];
  assign clock_polarity = mode_reg[`MODE_POLARITY];
  assign master_select = mode_reg[`MODE_MASTER];
  assign module_enable = ctrl_reg[`CTRL_ENABLE];
  assign soft_reset = ctrl_reg[`CTRL_SOFT];
  assign tx_word = txd_reg;
  assign tx_load = tx_load_reg;
  assign irq = irq_reg;

  //////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // software write of a one to the overrun bit
  sequence ovr_one_write;
    w1c_lane && wr_data[`FLAG_OVR] && !overrun_event && !soft_reset;
  endsequence

  // software write to transmit data
  sequence txd_write;
    w_txd && !tx_taken && !soft_reset;
  endsequence

  a_ovr_w1c_clear: assert property (ovr_one_write |=> !flags[`FLAG_OVR])
    else $error("overrun flag not cleared by write one");

  a_ovr_zero_keep: assert property (
    w_flags && !wr_data[`FLAG_OVR] && flags[`FLAG_OVR] && !soft_reset
    |=> flags[`FLAG_OVR])
    else $error("overrun flag lost on write zero");

  a_rxf_read_clear: assert property (
    rd_stb && r_rxd && !rx_load && !soft_reset |=> !flags[`FLAG_RXF])
    else $error("rx full not cleared by data read");

  a_txe_write_clear: assert property (txd_write |=> !flags[`FLAG_TXE] ##0 tx_load)
    else $error("tx empty not cleared or no load pulse");

  a_len_write: assert property (
    w_mode && wr_strb[1] |=> char_length == $past(wr_data[11:8]))
    else $error("char length not written");

  a_soft_restores: assert property (
    soft_reset && !w_ctrl |=> flags == FLAG_INIT ##1 flags == FLAG_INIT)
    else $error("flags not held at initial value by soft reset");

  a_irq_raise: assert property (
    |(flags & enables_reg[3:0]) |=> irq)
    else $error("interrupt missing");

  a_irq_drop: assert property (
    !(|(flags & enables_reg[3:0])) |=> !irq)
    else $error("interrupt stuck");

  a_busy_track: assert property (transfer_active_in |=> busy_reg)
    else $error("busy not following engine");

  a_reserved_zero: assert property (
    s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000 && (rd_word & ~(`MODE_MASK)) == 16'h0000
    || !r_mode)
    else $error("reserved bits not zero");

endmodule : sync_serial_ch1_register_bank

// ---- include/serial_cfg.svh ----
`ifndef SERIAL_CFG_SVH
`define SERIAL_CFG_SVH
// register indices; byte address is four times the index
`define IDX_MODE 16'h5270
`define IDX_CTRL 16'h5272
`define IDX_TXD 16'h5274
`define IDX_RXD 16'h5276
`define IDX_FLAGS 16'h5278
`define IDX_ENABLES 16'h527a
// mode register fields
`define MODE_LEN_HI 11
`define MODE_LEN_LO 8
`define MODE_PULLUP 5
`define MODE_BYPASS 4
`define MODE_LSB 3
`define MODE_PHASE 2
`define MODE_POLARITY 1
`define MODE_MASTER 0
`define MODE_MASK 16'h0f3f
`define MODE_RESET 16'h0700
// control register fields
`define CTRL_SOFT 1
`define CTRL_ENABLE 0
`define CTRL_MASK 16'h0003
`define CTRL_RESET 16'h0000
// data registers
`define DATA_RESET 16'h0000
// flag and enable register fields
`define FLAG_OVR 3
`define FLAG_TEND 2
`define FLAG_RXF 1
`define FLAG_TXE 0
`define FLAG_BUSY 7
`define FLAG_RESET 4'h1
`define ENABLE_MASK 16'h000f
`define ENABLE_RESET 16'h0000
`endif

// ---- include/serial_pkg.sv ----
package serial_pkg;
  // one 16-bit register word
  typedef logic [15:0] word16_type;
  // bus response codes
  typedef enum logic [1:0]
  {
    RESP_OKAY = 2'b00,
    RESP_SLVERR = 2'b10
  } axi_resp_type;
endpackage : serial_pkg

// ---- tb/tb_top.sv ----
`include "serial_cfg.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  ////////////////////////////////////////////////////////////////////////
  // clock, reset and stimulus signals
  logic aclk = 1'b0; // 20 mhz bus clock
  logic aresetn = 1'b0; // active low reset
  logic [18:0] awaddr = '0, araddr = '0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = '0;
  logic [3:0] wstrb = '0;
  logic [3:0] lanes = 4'h3; // byte lanes offered by the next write
  logic busy_in = 1'b0; // engine busy level
  logic [3:0] ev = '0; // {tx_taken, rx_load, transfer_end, overrun}
  logic [15:0] rx_in = '0; // word handed over with rx_load
  logic awready, wready, bvalid, arready, rvalid, tx_load, irq, mod_en, soft_rst;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [3:0] char_len;
  logic [5:0] mode_bits; // pullup, bypass, lsb, phase, polarity, master
  logic [15:0] tx_word;
  int miscompares = 0, checked = 0, cycles = 0, tx_loads = 0;
  logic [31:0] rd;
  logic [1:0] rsp;
  // half period of 25 ns
  always #25 aclk = ~aclk;
  ////////////////////////////////////////////////////////////////////////
  sync_serial_ch1_register_bank sync_serial_ch1_register_bank_i (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .transfer_active_in(busy_in), .overrun_event(ev[0]), .transfer_end_event(ev[1]),
    .rx_load(ev[2]), .rx_word(rx_in), .tx_taken(ev[3]),
    .char_length(char_len), .pullup_enable(mode_bits[5]), .divider_bypass(mode_bits[4]),
    .low_bit_first(mode_bits[3]), .clock_phase(mode_bits[2]),
    .clock_polarity(mode_bits[1]), .master_select(mode_bits[0]),
    .module_enable(mod_en), .soft_reset(soft_rst), .tx_word(tx_word),
    .tx_load(tx_load), .irq(irq)
  );
  ////////////////////////////////////////////////////////////////////////
  // watchdog and transmit load pulse counter
  always @(posedge aclk)
  begin
    cycles <= cycles + 1;
    if (tx_load === 1'b1) tx_loads <= tx_loads + 1;
    if (cycles == 20000)
    begin
      miscompares = miscompares + 1;
      finish_test();
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // verdict and end of run
  task automatic finish_test();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : finish_test
  // compares one value against its expectation
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    checked = checked + 1;
    if (seen !== exp)
    begin
      miscompares = miscompares + 1;
      $display("MISMATCH %0t %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask : chk
  // byte address of a register index
  function automatic logic [18:0] ba(input logic [15:0] idx);
    return {1'b0, idx, 2'b00};
  endfunction : ba
  task automatic idle(input int n);
    repeat (n) @(posedge aclk);
  endtask : idle
  // one axi4-lite write: address and data offered together, bready held until bvalid
  task automatic wr(input logic [15:0] idx, input logic [15:0] d, output logic [1:0] r);
    @(posedge aclk);
    awaddr <= ba(idx);
    awvalid <= 1'b1;
    wdata <= {16'h0000, d};
    wstrb <= lanes;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever
    begin
      @(posedge aclk);
      if (awvalid && awready === 1'b1) awvalid <= 1'b0;
      if (wvalid && wready === 1'b1) wvalid <= 1'b0;
      if (bvalid === 1'b1)
      begin
        r = bresp;
        bready <= 1'b0;
        break;
      end
    end
  endtask : wr
  // one axi4-lite read, rready held until rvalid
  task automatic rdr(input logic [15:0] idx, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    araddr <= ba(idx);
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever
    begin
      @(posedge aclk);
      if (arvalid && arready === 1'b1) arvalid <= 1'b0;
      if (rvalid === 1'b1)
      begin
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        break;
      end
    end
  endtask : rdr
  // write then read back one register
  task automatic wr_rd(input logic [15:0] idx, input logic [15:0] d, input logic [31:0] exp);
    wr(idx, d, rsp);
    rdr(idx, rd, rsp);
    chk(rd, exp, "read back");
  endtask : wr_rd
  // read one register and compare
  task automatic rd_chk(input logic [15:0] idx, input logic [31:0] exp);
    rdr(idx, rd, rsp);
    chk(rd, exp, "register read");
  endtask : rd_chk
  // one-cycle pulse on engine event strobes
  task automatic pulse(input logic [3:0] v);
    @(posedge aclk);
    ev <= v;
    @(posedge aclk);
    ev <= 4'h0;
  endtask : pulse
  ////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_reset_values();
    chk(char_len, 32'h7, "char length port");
    rd_chk(`IDX_MODE, 32'h0000_0700);
    rd_chk(`IDX_CTRL, 32'h0);
    rd_chk(`IDX_TXD, 32'h0);
    rd_chk(`IDX_RXD, 32'h0);
    rd_chk(`IDX_FLAGS, 32'h1);
    rd_chk(`IDX_ENABLES, 32'h0);
    chk(irq, 1'b0, "irq after reset");
  endtask : t_reset_values
  task automatic t_mode();
    wr_rd(`IDX_MODE, 16'hffff, 32'h0000_0f3f);
    chk({char_len, mode_bits}, 32'h3ff, "mode ports set");
    // upper lane only: the low byte keeps its old settings
    lanes = 4'h2;
    wr_rd(`IDX_MODE, 16'h0a15, 32'h0000_0a3f);
    lanes = 4'h3;
    wr_rd(`IDX_MODE, 16'h0a15, 32'h0000_0a15);
    chk({char_len, mode_bits}, 32'h295, "mode ports pattern");
  endtask : t_mode
  task automatic t_control();
    wr_rd(`IDX_CTRL, 16'hfffd, 32'h1);
    chk({soft_rst, mod_en}, 32'h1, "control ports");
  endtask : t_control
  task automatic t_transmit();
    wr_rd(`IDX_TXD, 16'ha55a, 32'h0000_a55a);
    chk(tx_word, 32'ha55a, "tx word port");
    chk(tx_loads, 1, "tx load pulse");
    rd_chk(`IDX_FLAGS, 32'h0);
    pulse(4'b1000);
    rd_chk(`IDX_FLAGS, 32'h1);
  endtask : t_transmit
  task automatic t_receive();
    rx_in <= 16'h1234;
    pulse(4'b0100);
    rx_in <= 16'hedcb;
    rd_chk(`IDX_FLAGS, 32'h3);
    wr(`IDX_FLAGS, 16'h0002, rsp);
    rd_chk(`IDX_FLAGS, 32'h3);
    wr(`IDX_RXD, 16'hffff, rsp);
    chk(rsp, 2'b00, "rx write response");
    rd_chk(`IDX_RXD, 32'h1234);
    rd_chk(`IDX_FLAGS, 32'h1);
  endtask : t_receive
  task automatic t_sticky();
    pulse(4'b0011);
    rd_chk(`IDX_FLAGS, 32'hd);
    wr(`IDX_FLAGS, 16'hfff3, rsp);
    rd_chk(`IDX_FLAGS, 32'hd);
    wr(`IDX_FLAGS, 16'h0008, rsp);
    rd_chk(`IDX_FLAGS, 32'h5);
    wr(`IDX_FLAGS, 16'h0004, rsp);
    rd_chk(`IDX_FLAGS, 32'h1);
    busy_in <= 1'b1;
    rd_chk(`IDX_FLAGS, 32'h81);
    busy_in <= 1'b0;
    rd_chk(`IDX_FLAGS, 32'h1);
  endtask : t_sticky
  task automatic t_interrupt();
    wr_rd(`IDX_ENABLES, 16'hffff, 32'hf);
    idle(2);
    chk(irq, 1'b1, "irq from tx empty");
    wr(`IDX_ENABLES, 16'h0008, rsp);
    idle(2);
    chk(irq, 1'b0, "irq masked");
    pulse(4'b0001);
    idle(2);
    chk(irq, 1'b1, "irq from overrun");
    wr(`IDX_FLAGS, 16'h0008, rsp);
    idle(2);
    chk(irq, 1'b0, "irq after clear");
  endtask : t_interrupt
  task automatic t_soft_reset();
    wr(`IDX_TXD, 16'h0001, rsp);
    pulse(4'b0001);
    wr(`IDX_CTRL, 16'h0003, rsp);
    rd_chk(`IDX_FLAGS, 32'h1);
    pulse(4'b0111);
    rd_chk(`IDX_FLAGS, 32'h1);
    rd_chk(`IDX_MODE, 32'h0000_0a15);
    rd_chk(`IDX_ENABLES, 32'h8);
    rd_chk(`IDX_TXD, 32'h0001);
    wr_rd(`IDX_CTRL, 16'h0000, 32'h0);
  endtask : t_soft_reset
  task automatic t_unmapped();
    wr(16'h527c, 16'hffff, rsp);
    chk(rsp, 2'b10, "unmapped write response");
    rdr(16'h527c, rd, rsp);
    chk(rsp, 2'b10, "unmapped read response");
    chk(rd, 32'h0, "unmapped read data");
  endtask : t_unmapped
  // hot reset in mid-run with flags, data and interrupt active
  task automatic t_hot_reset();
    wr(`IDX_TXD, 16'h00ff, rsp);
    pulse(4'b0001);
    idle(2);
    chk(irq, 1'b1, "irq before hot reset");
    aresetn <= 1'b0;
    idle(2);
    aresetn <= 1'b1;
    chk(irq, 1'b0, "irq in hot reset");
    chk(char_len, 32'h7, "char length in hot reset");
    rd_chk(`IDX_FLAGS, 32'h1);
    rd_chk(`IDX_MODE, 32'h0000_0700);
    rd_chk(`IDX_ENABLES, 32'h0);
    rd_chk(`IDX_TXD, 32'h0);
    rd_chk(`IDX_RXD, 32'h0);
  endtask : t_hot_reset
  ////////////////////////////////////////////////////////////////////////
  // main sequence
  initial
  begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset_values();
    t_mode();
    t_control();
    t_transmit();
    t_receive();
    t_sticky();
    t_interrupt();
    t_soft_reset();
    t_unmapped();
    t_hot_reset();
    finish_test();
  end
endmodule : tb_top
